//--- scc_osc_model.sv
`timescale 1ns/1ps
module scc_osc_model
   import scc_pkg::*;
(
   input wire logic clk_i,
   input wire logic [5:0] osc_en_i,
   input wire logic hse_stop_i,
   output logic [6:0] osc_clk_o = 7'h00,
   output logic [5:0] osc_rdy_o = 6'h00
);
   // Half periods in system cycles: msi hsi hse pll lse lsi usb
   localparam int HALF [7] = '{2, 2, 3, 2, 7, 5, 2};
   int ph [7] = '{default: 0};
   int up [6] = '{default: 0};
   logic [6:0] run;
   // Disabled oscillators stand still; slow internal RC always runs for the watchdog
   assign run = {osc_en_i[OSC_PLL], 1'b1, osc_en_i[4:3], osc_en_i[OSC_HSE] & !hse_stop_i, osc_en_i[1:0]};
   always @(posedge clk_i) begin
      for (int i = 0; i < 7; i++) begin
         if (run[i]) begin
            ph[i] <= (ph[i] == HALF[i] - 1) ? 0 : ph[i] + 1;
            if (ph[i] == HALF[i] - 1) osc_clk_o[i] <= ~osc_clk_o[i];
         end
      end
      // Ready comes a few cycles after enable, drops with it
      for (int i = 0; i < 6; i++) begin
         up[i] <= osc_en_i[i] ? ((up[i] < 4) ? up[i] + 1 : up[i]) : 0;
         osc_rdy_o[i] <= osc_en_i[i] && up[i] >= 3;
      end
   end
endmodule // scc_osc_model

//--- scc_pkg.sv
package scc_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_TRIM = 8'h0c;
   localparam logic [7:0] ADDR_RTCSEL = 8'h10;
   localparam logic [7:0] ADDR_GATE = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
   localparam logic [7:0] ADDR_MEAS = 8'h20;
   localparam logic [7:0] ADDR_MEAS_RES = 8'h24;

   // Oscillator indices (ready, enable and raw clock vectors)
   localparam int OSC_MSI = 0;
   localparam int OSC_HSI = 1;
   localparam int OSC_HSE = 2;
   localparam int OSC_PLL = 3;
   localparam int OSC_LSE = 4;
   localparam int OSC_LSI = 5;
   localparam int OSC_USB = 6;

   // Control register fields
   localparam int CTRL_MON = 6;
   localparam int CTRL_PLLSRC = 7;
   localparam logic [7:0] CTRL_RST = 8'h01;

   // Configuration register fields
   localparam int CFG_SEL = 0;
   localparam int CFG_AHB = 2;
   localparam int CFG_APB1 = 6;
   localparam int CFG_APB2 = 9;
   localparam int CFG_MCOSEL = 12;
   localparam int CFG_MCODIV = 15;
   localparam logic [17:0] CFG_RST = 18'h00000;

   // Trim register fields and reset values
   localparam int TRIM_MSI = 8;
   localparam int TRIM_HSI = 16;
   localparam logic [2:0] MSI_RANGE_RST = 3'h5;
   localparam logic [2:0] MSI_RANGE_MAX = 3'h6;
   localparam logic [7:0] MSI_TRIM_RST = 8'h80;
   localparam logic [4:0] HSI_TRIM_RST = 5'h10;

   // Gate register: core, memory, then eight bits per APB domain
   localparam int GATE_CORE = 0;
   localparam int GATE_MEM = 1;
   localparam int GATE_APB1 = 2;
   localparam int GATE_APB2 = 10;
   localparam logic [17:0] GATE_RST = 18'h00003;

   // Interrupt status bits
   localparam int IRQ_FAIL = 0;
   localparam int IRQ_SWITCH = 1;
   localparam int IRQ_MEAS = 2;
   localparam int IRQ_REFUSED = 3;

   // Master clock source codes
   localparam logic [1:0] SRC_MSI = 2'h0;
   localparam logic [1:0] SRC_HSI = 2'h1;
   localparam logic [1:0] SRC_HSE = 2'h2;
   localparam logic [1:0] SRC_PLL = 2'h3;

   // Real-time clock source codes
   localparam logic [1:0] RTC_OFF = 2'h0;
   localparam logic [1:0] RTC_LSE = 2'h1;
   localparam logic [1:0] RTC_LSI = 2'h2;
   localparam logic [1:0] RTC_HSE = 2'h3;

   // Frequencies in kHz
   localparam int HSI_KHZ = 16000;
   localparam int MAX_BUS_KHZ = 32000;

   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int HSE_FAIL_NS = 5000;
   localparam int HSE_FAIL_CYC = (HSE_FAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] MEAS_PERIODS = 4'h8;

   typedef enum logic [2:0] {
      SW_IDLE = 3'b001,
      SW_WAIT = 3'b010,
      SW_DONE = 3'b100
   } scc_sw_state_t;
endpackage

//--- scc_prescaler.sv
`timescale 1ns/1ps
module scc_prescaler (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic tick_i,
   input wire logic [3:0] shift_i,
   output logic tick_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } scc_presc_state_t;

   scc_presc_state_t s_q, s_d;
   logic [7:0] limit;

   // Divide by two to the power of shift_i, at most 256, one output pulse per limit+1 inputs
   always_comb begin
      limit = 8'((9'h001 << shift_i) - 9'h001);
      s_d = s_q;
      s_d.tick = 1'b0;
      if (tick_i) begin
         if (s_q.cnt >= limit) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule // scc_prescaler

//--- scc_sync.sv
`timescale 1ns/1ps
module scc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } scc_sync_state_t;

   scc_sync_state_t s_q, s_d;

   always_comb begin
      s_d.meta = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.stable;
endmodule // scc_sync

//--- scc_top.sv
// What this block does
// (RULE1) Master clock comes from multispeed RC, fast internal RC, fast external osc, or PLL.
// (RULE2) Fast external crystal, 1 to 24 MHz, is a source and may feed the PLL.
// (RULE3) Fast internal RC runs at 16 MHz, trimmable, and may feed the PLL.
// (RULE4) Multispeed RC offers seven ranges, 65 kHz to 4.2 MHz, with software trim.
// (RULE5) Multispeed RC can be measured against the slow external osc for trimming.
// (RULE6) A programmable prescaler lowers the clock delivered to CPU and peripherals.
// (RULE7) Source changes in run mode by a register write, without unsafe transitions.
// (RULE8) Core, memory and each peripheral clock can be gated off individually.
// (RULE9) Slow external 32.768 kHz and slow internal 37 kHz clocks; the latter feeds the watchdog.
// (RULE10) Slow internal RC can be measured using the fast internal RC as reference.
// (RULE11) RTC/LCD clock is slow internal, slow external or fast external, independent of master.
// (RULE12) PLL provides a dedicated 48 MHz clock for USB.
// (RULE13) After reset the master clock runs from the multispeed RC at 2 MHz.
// (RULE14) With monitoring on, fast external failure switches to fast internal RC and interrupts.
// (RULE15) One selected internal clock is routed to the clock output pin.
// (RULE16) Separate AHB, APB1, APB2 prescalers; no domain above 32 MHz.
// (RULE17) Switch only once the new source is ready; report the active source. The failure fallback to fast internal RC skips the ready wait.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module scc_top
   import scc_pkg::*;
#(
   parameter int HSE_KHZ = 8000,
   parameter int PLL_KHZ = 32000
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o,
   input wire logic [6:0] osc_clk_i,
   input wire logic [5:0] osc_rdy_i,
   output logic [5:0] osc_en_o,
   output logic pll_src_o,
   output logic [2:0] msi_range_o,
   output logic [7:0] msi_trim_o,
   output logic [4:0] hsi_trim_o,
   output logic master_clock_en_o,
   output logic ahb_en_o,
   output logic core_en_o,
   output logic mem_en_o,
   output logic [7:0] apb1_en_o,
   output logic [7:0] apb2_en_o,
   output logic usb_clk_en_o,
   output logic rtc_lcd_en_o,
   output logic watchdog_en_o,
   output logic clock_output_pin_o,
   output logic [1:0] active_src_o
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [17:0] cfg;
      logic [2:0] msi_range;
      logic [7:0] msi_trim;
      logic [4:0] hsi_trim;
      logic [1:0] rtc_sel;
      logic [17:0] gate;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [6:0] clk_prev;
      logic [1:0] active;
      scc_sw_state_t sw;
      logic [7:0] hse_idle;
      logic hse_failed;
      logic meas_busy;
      logic meas_mode;
      logic [3:0] meas_ref;
      logic [23:0] meas_cnt;
      logic [23:0] meas_res;
      logic master_en;
      logic core_en;
      logic mem_en;
      logic [7:0] apb1_en;
      logic [7:0] apb2_en;
      logic usb_en;
      logic rtc_en;
      logic wdg_en;
      logic clock_output_pin;
      logic [31:0] rdata;
   } scc_state_t;

   localparam scc_state_t STATE_RST = '{
      ctrl: CTRL_RST,
      cfg: CFG_RST,
      msi_range: MSI_RANGE_RST,
      msi_trim: MSI_TRIM_RST,
      hsi_trim: HSI_TRIM_RST,
      rtc_sel: RTC_OFF,
      gate: GATE_RST,
      active: SRC_MSI,
      sw: SW_IDLE,
      default: '0
   };

   scc_state_t s_q, s_d;
   logic [12:0] sync_lvl;
   logic [6:0] clk_lvl;
   logic [5:0] rdy;
   logic [6:0] tick;
   logic ahb_tick;
   logic apb1_tick;
   logic apb2_tick;
   logic mco_tick;
   logic mco_src;
   logic [3:0] irq_set;
   logic [3:0] irq_clr;
   logic [1:0] new_sel;
   logic [3:0] new_ahb;
   logic meas_ref_tick;
   logic meas_tick;
   logic uses_hse;

   function automatic int msi_khz(input logic [2:0] range);
      case (range)
         3'h0: msi_khz = 65;
         3'h1: msi_khz = 131;
         3'h2: msi_khz = 262;
         3'h3: msi_khz = 524;
         3'h4: msi_khz = 1050;
         3'h5: msi_khz = 2100;
         default: msi_khz = 4200;
      endcase
   endfunction

   function automatic int src_khz(input logic [1:0] sel, input logic [2:0] range);
      case (sel)
         SRC_MSI: src_khz = msi_khz(range);
         SRC_HSI: src_khz = HSI_KHZ;
         SRC_HSE: src_khz = HSE_KHZ;
         default: src_khz = PLL_KHZ;
      endcase
   endfunction

   function automatic logic src_tick(input logic [1:0] sel, input logic [6:0] t);
      case (sel)
         SRC_MSI: src_tick = t[OSC_MSI];
         SRC_HSI: src_tick = t[OSC_HSI];
         SRC_HSE: src_tick = t[OSC_HSE];
         default: src_tick = t[OSC_PLL];
      endcase
   endfunction

   // Raw oscillator levels and ready flags come from other clock domains
   scc_sync #(
      .WIDTH(13)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i({osc_rdy_i, osc_clk_i}),
      .sync_o(sync_lvl)
   );

   assign clk_lvl = sync_lvl[6:0];
   assign rdy = sync_lvl[12:7];
   // Rising edges of the sampled oscillators; sources above 10 MHz alias at this rate
   assign tick = clk_lvl & ~s_q.clk_prev;

   scc_prescaler u_ahb (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(s_q.master_en),
      .shift_i(s_q.cfg[CFG_AHB +: 4]), // see (RULE6)
      .tick_o(ahb_tick)
   );

   scc_prescaler u_apb1 (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(ahb_tick),
      .shift_i({1'b0, s_q.cfg[CFG_APB1 +: 3]}), // see (RULE16)
      .tick_o(apb1_tick)
   );

   scc_prescaler u_apb2 (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(ahb_tick),
      .shift_i({1'b0, s_q.cfg[CFG_APB2 +: 3]}), // see (RULE16)
      .tick_o(apb2_tick)
   );

   scc_prescaler u_mco (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tick_i(mco_src),
      .shift_i({1'b0, s_q.cfg[CFG_MCODIV +: 3]}),
      .tick_o(mco_tick)
   );

   // Clock routed to the output pin
   always_comb begin
      case (s_q.cfg[CFG_MCOSEL +: 3])
         3'h1: mco_src = s_q.master_en;
         3'h2: mco_src = tick[OSC_HSI];
         3'h3: mco_src = tick[OSC_MSI];
         3'h4: mco_src = tick[OSC_HSE];
         3'h5: mco_src = tick[OSC_PLL];
         3'h6: mco_src = tick[OSC_LSI];
         3'h7: mco_src = tick[OSC_LSE];
         default: mco_src = 1'b0;
      endcase
   end

   always_comb begin
      s_d = s_q;
      irq_set = 4'h0;
      irq_clr = 4'h0;
      s_d.clk_prev = clk_lvl;
      s_d.rdata = 32'h00000000;
      new_sel = reg_wdata_i[CFG_SEL +: 2];
      new_ahb = reg_wdata_i[CFG_AHB +: 4];
      meas_ref_tick = s_q.meas_mode ? tick[OSC_LSE] : tick[OSC_LSI]; // see (RULE5) (RULE10)
      meas_tick = s_q.meas_mode ? tick[OSC_MSI] : tick[OSC_HSI];
      uses_hse = (s_q.active == SRC_HSE) || (s_q.active == SRC_PLL && s_q.ctrl[CTRL_PLLSRC]);

      // Register writes
      if (reg_wr_i) begin
         if (reg_addr_i == ADDR_CTRL) begin
            s_d.ctrl = reg_wdata_i[7:0];
            if (reg_wdata_i[OSC_HSE]) begin
               s_d.hse_failed = 1'b0;
            end
         end else if (reg_addr_i == ADDR_CFG) begin
            // A prescaler or source setting that would overclock the AHB is refused
            if ((src_khz(new_sel, s_q.msi_range) >> new_ahb) > MAX_BUS_KHZ || new_ahb > 4'h8) begin // see (RULE16)
               irq_set[IRQ_REFUSED] = 1'b1;
            end else begin
               s_d.cfg = reg_wdata_i[17:0]; // see (RULE7)
            end
         end else if (reg_addr_i == ADDR_TRIM) begin
            // Only seven ranges exist; the eighth code reads back as the top one
            s_d.msi_range = (reg_wdata_i[2:0] > MSI_RANGE_MAX) ? MSI_RANGE_MAX : reg_wdata_i[2:0]; // see (RULE4)
            s_d.msi_trim = reg_wdata_i[TRIM_MSI +: 8]; // see (RULE4)
            s_d.hsi_trim = reg_wdata_i[TRIM_HSI +: 5]; // see (RULE3)
         end else if (reg_addr_i == ADDR_RTCSEL) begin
            s_d.rtc_sel = reg_wdata_i[1:0];
         end else if (reg_addr_i == ADDR_GATE) begin
            s_d.gate = reg_wdata_i[17:0];
         end else if (reg_addr_i == ADDR_IRQ_STAT) begin
            irq_clr = reg_wdata_i[3:0];
         end else if (reg_addr_i == ADDR_IRQ_MASK) begin
            s_d.irq_mask = reg_wdata_i[3:0];
         end else if (reg_addr_i == ADDR_MEAS) begin
            if (reg_wdata_i[0]) begin
               s_d.meas_busy = 1'b1;
               s_d.meas_mode = reg_wdata_i[1];
               s_d.meas_ref = 4'h0;
               s_d.meas_cnt = 24'h000000;
            end
         end
      end

      // Register reads; answer stands one cycle only
      if (reg_rd_i) begin
         if (reg_addr_i == ADDR_CTRL) begin
            s_d.rdata = {24'h000000, s_q.ctrl};
         end else if (reg_addr_i == ADDR_CFG) begin
            s_d.rdata = {14'h0000, s_q.cfg};
         end else if (reg_addr_i == ADDR_STAT) begin
            s_d.rdata = {22'h000000, s_q.hse_failed, s_q.sw != SW_IDLE, s_q.active, rdy}; // see (RULE17)
         end else if (reg_addr_i == ADDR_TRIM) begin
            s_d.rdata = {11'h000, s_q.hsi_trim, s_q.msi_trim, 5'h00, s_q.msi_range};
         end else if (reg_addr_i == ADDR_RTCSEL) begin
            s_d.rdata = {30'h00000000, s_q.rtc_sel};
         end else if (reg_addr_i == ADDR_GATE) begin
            s_d.rdata = {14'h0000, s_q.gate};
         end else if (reg_addr_i == ADDR_IRQ_STAT) begin
            s_d.rdata = {28'h0000000, s_q.irq_stat};
         end else if (reg_addr_i == ADDR_IRQ_MASK) begin
            s_d.rdata = {28'h0000000, s_q.irq_mask};
         end else if (reg_addr_i == ADDR_MEAS) begin
            s_d.rdata = {30'h00000000, s_q.meas_mode, s_q.meas_busy};
         end else if (reg_addr_i == ADDR_MEAS_RES) begin
            s_d.rdata = {8'h00, s_q.meas_res};
         end
      end

      // Count measured ticks across whole reference periods only
      if (s_q.meas_busy) begin
         if (meas_tick && s_q.meas_ref != 4'h0) begin
            s_d.meas_cnt = s_q.meas_cnt + 24'h000001;
         end
         if (meas_ref_tick) begin
            if (s_q.meas_ref == MEAS_PERIODS) begin
               s_d.meas_busy = 1'b0;
               s_d.meas_res = s_q.meas_cnt; // see (RULE10)
               irq_set[IRQ_MEAS] = 1'b1;
            end else begin
               s_d.meas_ref = s_q.meas_ref + 4'h1;
            end
         end
      end

      // Glitch-free switch: hold the old source until the new one is ready
      case (s_q.sw)
         SW_IDLE: begin
            if (s_q.cfg[CFG_SEL +: 2] != s_q.active) begin
               s_d.sw = SW_WAIT;
            end
         end
         SW_WAIT: begin
            if (s_q.cfg[CFG_SEL +: 2] == s_q.active) begin
               s_d.sw = SW_IDLE;
            end else if (rdy[s_q.cfg[CFG_SEL +: 2]] && s_q.ctrl[s_q.cfg[CFG_SEL +: 2]]) begin // see (RULE17)
               s_d.active = s_q.cfg[CFG_SEL +: 2]; // see (RULE1) (RULE7)
               s_d.sw = SW_DONE;
               irq_set[IRQ_SWITCH] = 1'b1;
            end
         end
         SW_DONE: begin
            s_d.sw = SW_IDLE;
         end
         default: begin
            s_d.sw = SW_IDLE;
         end
      endcase

      // Fast external oscillator watchdog on its edges
      if (!s_q.ctrl[CTRL_MON] || !s_q.ctrl[OSC_HSE] || tick[OSC_HSE] || s_q.hse_failed) begin
         s_d.hse_idle = 8'h00;
      end else if (s_q.hse_idle == 8'(HSE_FAIL_CYC)) begin
         s_d.hse_failed = 1'b1; // see (RULE14)
         s_d.hse_idle = 8'h00;
         s_d.ctrl[OSC_HSE] = 1'b0;
         irq_set[IRQ_FAIL] = 1'b1; // see (RULE14)
         if (uses_hse) begin
            s_d.ctrl[OSC_HSI] = 1'b1;
            s_d.active = SRC_HSI; // see (RULE14)
            s_d.cfg[CFG_SEL +: 2] = SRC_HSI;
            s_d.sw = SW_IDLE;
         end
      end else begin
         s_d.hse_idle = s_q.hse_idle + 8'h01;
      end

      // Sticky status: a set in the same cycle beats a write-one clear
      s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;

      // Registered clock enables
      s_d.master_en = src_tick(s_q.active, tick); // see (RULE1) (RULE13)
      s_d.core_en = ahb_tick && s_q.gate[GATE_CORE]; // see (RULE8)
      s_d.mem_en = ahb_tick && s_q.gate[GATE_MEM]; // see (RULE8)
      s_d.apb1_en = {8{apb1_tick}} & s_q.gate[GATE_APB1 +: 8]; // see (RULE8) (RULE16)
      s_d.apb2_en = {8{apb2_tick}} & s_q.gate[GATE_APB2 +: 8]; // see (RULE8) (RULE16)
      s_d.usb_en = tick[OSC_USB] && s_q.ctrl[OSC_PLL] && rdy[OSC_PLL]; // see (RULE12)
      s_d.wdg_en = tick[OSC_LSI]; // see (RULE9)
      case (s_q.rtc_sel)
         RTC_LSE: s_d.rtc_en = tick[OSC_LSE]; // see (RULE9) (RULE11)
         RTC_LSI: s_d.rtc_en = tick[OSC_LSI]; // see (RULE11)
         RTC_HSE: s_d.rtc_en = tick[OSC_HSE]; // see (RULE11)
         default: s_d.rtc_en = 1'b0;
      endcase
      if (s_q.cfg[CFG_MCOSEL +: 3] == 3'h0) begin
         s_d.clock_output_pin = 1'b0;
      end else if (mco_tick) begin
         s_d.clock_output_pin = ~s_q.clock_output_pin; // see (RULE15)
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= STATE_RST; // see (RULE13)
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign irq_o = |(s_q.irq_stat & s_q.irq_mask); // see (RULE14)
   assign osc_en_o = s_q.ctrl[5:0]; // see (RULE2) (RULE9)
   assign pll_src_o = s_q.ctrl[CTRL_PLLSRC]; // see (RULE2) (RULE3)
   assign msi_range_o = s_q.msi_range;
   assign msi_trim_o = s_q.msi_trim;
   assign hsi_trim_o = s_q.hsi_trim;
   assign master_clock_en_o = s_q.master_en;
   assign ahb_en_o = ahb_tick;
   assign core_en_o = s_q.core_en;
   assign mem_en_o = s_q.mem_en;
   assign apb1_en_o = s_q.apb1_en;
   assign apb2_en_o = s_q.apb2_en;
   assign usb_clk_en_o = s_q.usb_en;
   assign rtc_lcd_en_o = s_q.rtc_en;
   assign watchdog_en_o = s_q.wdg_en;
   assign clock_output_pin_o = s_q.clock_output_pin;
   assign active_src_o = s_q.active;
endmodule // scc_top

//--- scc_top_properties.sv
`timescale 1ns/1ps
module scc_top_properties
   import scc_pkg::*;
#(
   parameter int HSE_KHZ = 8000,
   parameter int PLL_KHZ = 32000
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic irq_o,
   input wire logic [6:0] osc_clk_i,
   input wire logic [5:0] osc_rdy_i,
   input wire logic [5:0] osc_en_o,
   input wire logic pll_src_o,
   input wire logic [2:0] msi_range_o,
   input wire logic [7:0] msi_trim_o,
   input wire logic [4:0] hsi_trim_o,
   input wire logic master_clock_en_o,
   input wire logic ahb_en_o,
   input wire logic core_en_o,
   input wire logic mem_en_o,
   input wire logic [7:0] apb1_en_o,
   input wire logic [7:0] apb2_en_o,
   input wire logic usb_clk_en_o,
   input wire logic rtc_lcd_en_o,
   input wire logic watchdog_en_o,
   input wire logic clock_output_pin_o,
   input wire logic [1:0] active_src_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence lsi_rise_s;
      $rose(osc_clk_i[OSC_LSI]);
   endsequence
   sequence wd_tick_s;
      ##[2:4] watchdog_en_o;
   endsequence
   master_pulse_a: assert property (master_clock_en_o |=> !master_clock_en_o)
      else $error("master tick too long");
   ahb_pulse_a: assert property (ahb_en_o |=> !ahb_en_o)
      else $error("ahb tick too long");
   apb_pulse_a: assert property (apb1_en_o != 8'h00 |=> apb1_en_o == 8'h00)
      else $error("apb tick too long");
   core_gate_a: assert property (core_en_o |-> $past(ahb_en_o))
      else $error("core tick without ahb tick");
   mem_gate_a: assert property (mem_en_o |-> $past(ahb_en_o))
      else $error("memory tick without ahb tick");
   msi_range_a: assert property (msi_range_o <= MSI_RANGE_MAX)
      else $error("multispeed range out of bounds");
   usb_gate_a: assert property (usb_clk_en_o |-> $past(osc_en_o[OSC_PLL]))
      else $error("usb tick with pll off");
   switch_ready_a: assert property ($changed(active_src_o) && active_src_o == SRC_HSE |->
      $past(osc_rdy_i[OSC_HSE], 3) && $past(osc_en_o[OSC_HSE])) else $error("switch before ready");
   watchdog_tick_a: assert property (lsi_rise_s |-> wd_tick_s)
      else $error("watchdog tick missing");
endmodule // scc_top_properties

//--- scc_top_tb.sv
`timescale 1ns/1ps
module scc_top_tb
   import scc_pkg::*;
;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   localparam int RTC_N [4] = '{0, 30, 42, 70};
   localparam int MCO_N [8] = '{0, 20, 30, 30, 20, 30, 12, 9};
   localparam int MEAS_N [2] = '{20, 28};
   logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, hse_stop = 1'b0;
   logic rd_pend = 1'b0, mco_p = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, m_v, r;
   logic irq_o, pll_src_o, master_clock_en_o, ahb_en_o, core_en_o, mem_en_o, usb_clk_en_o;
   logic rtc_lcd_en_o, watchdog_en_o, clock_output_pin_o;
   logic [6:0] osc_clk_i;
   logic [5:0] osc_rdy_i, osc_en_o;
   logic [7:0] msi_trim_o, apb1_en_o, apb2_en_o, ev;
   logic [4:0] hsi_trim_o;
   logic [2:0] msi_range_o;
   logic [1:0] active_src_o;
   logic [31:0] exp_q[$], msk_q[$];
   int cnt [8] = '{default: 0};
   int base [8], d [8];
   int n_mismatch = 0, comparisons = 0, k;
   scc_top i_scc_top (.*);
   scc_osc_model i_scc_osc_model (.clk_i, .osc_en_i(osc_en_o), .hse_stop_i(hse_stop), .osc_clk_o(osc_clk_i),
      .osc_rdy_o(osc_rdy_i));
   always #25 clk_i = ~clk_i;
   assign ev = {clock_output_pin_o ^ mco_p, watchdog_en_o, usb_clk_en_o, rtc_lcd_en_o, apb1_en_o[0], core_en_o,
      ahb_en_o, master_clock_en_o};
   // Tick counters, and the read-data checker fed from the note queue
   always @(posedge clk_i) begin
      mco_p <= clock_output_pin_o;
      for (int i = 0; i < 8; i++) cnt[i] <= cnt[i] + int'(ev[i]);
      if (rd_pend) begin
         m_v = msk_q.pop_front();
         chk("read data", exp_q.pop_front() & m_v, reg_rdata_o & m_v);
      end
      rd_pend = reg_rd_i;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic near(input string nm, input int e, input int g);
      comparisons++;
      if (g < e - 1 || g > e + 1) begin
         n_mismatch++;
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic span(input int n);
      base = cnt;
      repeat (n) @(posedge clk_i);
      foreach (d[i]) d[i] = cnt[i] - base[i];
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end
   initial begin
      r = $urandom(81337);
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      chk("active source", 32'(SRC_MSI), 32'(active_src_o));
      rd(ADDR_CTRL, 32'(CTRL_RST), ALL);
      rd(ADDR_CFG, 32'(CFG_RST), ALL);
      rd(ADDR_TRIM, {11'h0, HSI_TRIM_RST, MSI_TRIM_RST, 5'h00, MSI_RANGE_RST}, ALL);
      rd(ADDR_GATE, 32'(GATE_RST), ALL);
      rd(8'h30, 32'h0, ALL);
      span(200);
      near("master ticks", 50, d[0]);
      $display("test reset done");
      r = $urandom();
      wr(ADDR_TRIM, {11'h0, r[4:0], r[15:8], 5'h00, 3'h7});
      rd(ADDR_TRIM, {11'h0, r[4:0], r[15:8], 5'h00, MSI_RANGE_MAX}, ALL);
      chk("trims", {19'h0, r[4:0], r[15:8]}, {19'h0, hsi_trim_o, msi_trim_o});
      chk("range", 32'(MSI_RANGE_MAX), 32'(msi_range_o));
      wr(ADDR_IRQ_MASK, 32'hf);
      wr(ADDR_CFG, 32'h25);
      rd(ADDR_CFG, 32'(CFG_RST), ALL);
      rd(ADDR_IRQ_STAT, 32'h8, ALL);
      chk("irq", 32'h1, 32'(irq_o));
      wr(ADDR_IRQ_STAT, 32'h8);
      chk("irq", 32'h0, 32'(irq_o));
      $display("test trim and refusal done");
      wr(ADDR_CFG, 32'(SRC_HSE));
      span(60);
      chk("active source", 32'(SRC_MSI), 32'(active_src_o));
      rd(ADDR_STAT, 32'h100, 32'h100);
      wr(ADDR_CTRL, 32'h3f);
      for (k = 0; k < 40 && active_src_o !== SRC_HSE; k++) @(posedge clk_i);
      chk("active source", 32'(SRC_HSE), 32'(active_src_o));
      chk("irq", 32'h1, 32'(irq_o));
      rd(ADDR_IRQ_STAT, 32'h2, ALL);
      wr(ADDR_IRQ_STAT, 32'h2);
      chk("irq", 32'h0, 32'(irq_o));
      wr(ADDR_CFG, 32'h4a);
      span(600);
      near("master ticks", 100, d[0]);
      near("ahb ticks", 25, d[1]);
      near("core ticks", 25, d[2]);
      near("apb ticks", 0, d[3]);
      wr(ADDR_GATE, 32'h4);
      span(600);
      near("core ticks", 0, d[2]);
      near("apb ticks", 12, d[3]);
      $display("test switch and prescale done");
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_RTCSEL, 32'(c));
         span(420);
         near("rtc ticks", RTC_N[c], d[4]);
         near("watchdog ticks", 42, d[6]);
      end
      near("usb ticks", 105, d[5]);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_CFG, 32'(SRC_HSE) | (32'(s) << CFG_MCOSEL));
         span(120);
         near("pin toggles", MCO_N[s], d[7]);
      end
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_MEAS, 32'h1 | (32'(m) << 1));
         for (k = 0; k < 400 && irq_o !== 1'b1; k++) @(posedge clk_i);
         rd(ADDR_MEAS_RES, 32'(MEAS_N[m]), 32'hffff_fffe);
         wr(ADDR_IRQ_STAT, 32'h4);
      end
      $display("test clock routing and measure done");
      wr(ADDR_CTRL, 32'h7f);
      hse_stop <= 1'b1;
      for (k = 0; k < 200 && active_src_o !== SRC_HSI; k++) @(posedge clk_i);
      chk("fallback delay", 32'h1, 32'(k >= 90 && k < 130));
      chk("active source", 32'(SRC_HSI), 32'(active_src_o));
      rd(ADDR_CTRL, 32'h0, 32'h4);
      rd(ADDR_CFG, 32'(SRC_HSI), 32'h3);
      rd(ADDR_IRQ_STAT, 32'h1, 32'h1);
      chk("irq", 32'h1, 32'(irq_o));
      $display("test failure done");
      final_report();
   end
endmodule // scc_top_tb
bind scc_top scc_top_properties #(.HSE_KHZ(HSE_KHZ), .PLL_KHZ(PLL_KHZ)) i_scc_top_properties (.*);
